// [verilog/ucdr_defines.svh]
`ifndef UCDR_DEFINES_SVH
`define UCDR_DEFINES_SVH

// samples per bit, voting sample numbers, widths, fifo depth and reset values
`define UCDR_SPB_NORMAL    5'd16
`define UCDR_SPB_DOUBLE    5'd8
`define UCDR_VOTE_N_FIRST  5'd8
`define UCDR_VOTE_D_FIRST  5'd4
`define UCDR_DATA_BITS     9
`define UCDR_DATA_BITS_DEF 4'd8
`define UCDR_FIFO_DEPTH    8
`define UCDR_BAUD_DIV_DEF  16'd0
`define UCDR_SAMPLE_RESET  5'h00
`define UCDR_BIT_RESET     4'h0
`define UCDR_FIFO_WIDTH    10

`endif

// [verilog/ucdr_pkg.sv]
package ucdr_pkg;

    typedef enum logic [3:0] {
        UCDR_IDLE  = 4'b0001,
        UCDR_START = 4'b0010,
        UCDR_BITS  = 4'b0100,
        UCDR_STOP  = 4'b1000
    } ucdr_state_e;

    typedef logic [4:0] ucdr_sample_t;

endpackage : ucdr_pkg

// [verilog/ucdr_fifo.sv]
`timescale 1ns/10ps
module ucdr_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic [WIDTH-1:0] out_q, out_d;
    logic             ov_q, ov_d;
    logic             wr, rd;

    // output word sits in a register; memory holds the rest
    always_comb begin
        // the output register counts toward depth, so capacity is DEPTH
        wr    = in_valid && in_ready;
        rd    = (cnt_q != '0) && (!ov_q || out_ready);
        wp_d  = wp_q;
        rp_d  = rp_q;
        cnt_d = cnt_q;
        out_d = out_q;
        ov_d  = ov_q;
        if (ov_q && out_ready) begin
            ov_d = 1'b0;
        end
        if (wr) begin
            wp_d = wp_q + 1'b1;
        end
        if (rd) begin
            out_d = mem_q[rp_q];
            ov_d  = 1'b1;
            rp_d  = rp_q + 1'b1;
        end
        cnt_d = cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
        if (flush) begin
            wp_d  = '0;
            rp_d  = '0;
            cnt_d = '0;
            ov_d  = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
            out_q <= '0;
            ov_q  <= 1'b0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
            out_q <= out_d;
            ov_q  <= ov_d;
        end
    end

    always_ff @(posedge clock) begin
        if (wr) begin
            mem_q[wp_q] <= in_data;
        end
    end

    assign in_ready  = (cnt_q + (AW+1)'(ov_q)) != (AW+1)'(DEPTH);
    assign out_data  = out_q;
    assign out_valid = ov_q;

endmodule : ucdr_fifo

// [verilog/ucdr_rx.sv]
// How it works
// RULE1 - samples come at 16 per bit normally and 8 per bit in double speed.
// RULE2 - while the line idles the sample counter rests at zero.
// RULE3 - a falling edge starts detection with the first low sample as one.
// RULE4 - normal mode checks the start bit on samples 8, 9 and 10.
// RULE5 - double speed checks the start bit on samples 4, 5 and 6.
// RULE6 - two or more high votes reject the start bit as noise.
// RULE7 - a valid start bit realigns bit timing, again for every frame.
// RULE8 - each bit walks 16 or 8 sample states, one per sample number.
// RULE9 - each bit is the majority of its three centre samples.
// RULE10 - recovery ends at the first stop bit; later stop bits are ignored.
// RULE11 - a low first stop bit sets the frame error flag of that frame.
// RULE12 - in normal mode start search resumes right after the stop vote.
// RULE13 - double_speed_select high picks double speed, low picks normal.
// RULE14 - the transmitter must keep its rate inside the accepted ratios.
// RULE15 - each end should take half the total baud rate error budget.
// RULE16 - a high stop bit clears the flag, which rides the fifo with data.
// RULE17 - the line is synchronised, and disabling the receiver aborts all.
`timescale 1ns/10ps
`include "ucdr_defines.svh"
module ucdr_rx
    import ucdr_pkg::*;
#(
    parameter int          DATA_BITS = `UCDR_DATA_BITS,
    parameter int          DEPTH     = `UCDR_FIFO_DEPTH,
    parameter logic [15:0] BAUD_DIV  = `UCDR_BAUD_DIV_DEF
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             rxd,
    input  wire logic             receiver_enable_bit,
    input  wire logic             double_speed_select,
    input  wire logic [3:0]       data_bits,
    input  wire logic [15:0]      baud_divisor_value,
    output logic [DATA_BITS-1:0]  rx_data,
    output logic                  frame_error_flag,
    output logic                  rx_valid,
    input  wire logic             rx_ready,
    output logic                  rx_overrun
);
    logic               sync1_q, sync2_q;
    logic [15:0]        div_q, div_d;
    logic               tick_q, tick_d;
    ucdr_state_e        st_q, st_d;
    ucdr_sample_t       smp_q, smp_d;
    logic [3:0]         bit_q, bit_d;
    logic [1:0]         votes_q, votes_d;
    logic [DATA_BITS-1:0] sh_q, sh_d;
    logic               prev_q, prev_d;
    logic               push_q, push_d;
    logic               fe_q, fe_d;
    logic               ovr_q, ovr_d;
    logic [4:0]         spb, vfirst;
    logic               vote;
    logic               fifo_ready, fifo_valid, flush;
    logic [DATA_BITS:0] fifo_out;

    // the line is taken through two flops before anything looks at it
    always_ff @(posedge clock) begin
        if (rst) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else begin
            sync1_q <= rxd; // [RULE17]
            sync2_q <= sync1_q;
        end
    end

    // sample tick: one pulse per sample period
    // exact division keeps this end inside its half of the budget [RULE15]
    always_comb begin
        tick_d = 1'b0;
        div_d  = div_q - 16'h0001;
        if (div_q == 16'h0000) begin
            div_d  = baud_divisor_value;
            tick_d = 1'b1;
        end
        if (!receiver_enable_bit) begin
            div_d = 16'h0000;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            div_q  <= BAUD_DIV;
            tick_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            tick_q <= tick_d;
        end
    end

    assign spb    = double_speed_select ? `UCDR_SPB_DOUBLE
                                        : `UCDR_SPB_NORMAL; // [RULE1] [RULE13]
    assign vfirst = double_speed_select ? `UCDR_VOTE_D_FIRST
                                        : `UCDR_VOTE_N_FIRST; // [RULE4] [RULE5]
    assign flush  = !receiver_enable_bit;
    // majority of the two earlier centre samples plus the current one
    assign vote   = (votes_q == 2'd2) || (votes_q == 2'd1 && sync2_q); // [RULE9]

    always_comb begin
        st_d    = st_q;
        smp_d   = smp_q;
        bit_d   = bit_q;
        votes_d = votes_q;
        sh_d    = sh_q;
        prev_d  = prev_q;
        push_d  = 1'b0;
        fe_d    = fe_q;
        ovr_d   = ovr_q;
        if (push_q && !fifo_ready) begin
            ovr_d = 1'b1;
        end else if (push_q) begin
            ovr_d = 1'b0;
        end
        if (tick_q) begin
            prev_d = sync2_q;
            smp_d  = smp_q + 5'd1;
            if (smp_q >= vfirst && smp_q < vfirst + 5'd2 && sync2_q) begin
                votes_d = votes_q + 2'd1;
            end
            case (st_q)
                UCDR_IDLE: begin
                    smp_d   = `UCDR_SAMPLE_RESET; // [RULE2]
                    votes_d = 2'd0;
                    if (prev_q && !sync2_q) begin
                        smp_d = 5'd2; // [RULE3]
                        st_d  = UCDR_START;
                    end
                end
                UCDR_START: begin
                    if (smp_q == vfirst + 5'd2) begin
                        votes_d = 2'd0;
                        smp_d   = 5'd1;
                        if (vote) begin
                            st_d  = UCDR_IDLE; // [RULE6]
                            smp_d = `UCDR_SAMPLE_RESET;
                        end else begin
                            // resync: count on through the start bit tail
                            smp_d = vfirst + 5'd3; // [RULE7]
                            st_d  = UCDR_BITS;
                            bit_d = `UCDR_BIT_RESET;
                        end
                    end
                end
                UCDR_BITS: begin
                    if (smp_q == vfirst + 5'd2) begin
                        sh_d    = {vote, sh_q[DATA_BITS-1:1]}; // [RULE9]
                        votes_d = 2'd0;
                        bit_d   = bit_q + 4'd1;
                    end
                    if (smp_q == spb) begin
                        smp_d = 5'd1; // [RULE8]
                        if (bit_q == data_bits) begin
                            st_d = UCDR_STOP;
                        end
                    end
                end
                UCDR_STOP: begin
                    if (smp_q == vfirst + 5'd2) begin
                        fe_d    = !vote; // [RULE11] [RULE16]
                        push_d  = 1'b1;
                        votes_d = 2'd0;
                        smp_d   = `UCDR_SAMPLE_RESET;
                        st_d    = UCDR_IDLE; // [RULE10] [RULE12]
                    end
                end
                default: st_d = UCDR_IDLE;
            endcase
        end
        if (!receiver_enable_bit) begin
            st_d    = UCDR_IDLE; // [RULE17]
            smp_d   = `UCDR_SAMPLE_RESET;
            votes_d = 2'd0;
            prev_d  = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_q    <= UCDR_IDLE;
            smp_q   <= `UCDR_SAMPLE_RESET;
            bit_q   <= `UCDR_BIT_RESET;
            votes_q <= 2'd0;
            sh_q    <= '0;
            prev_q  <= 1'b1;
            push_q  <= 1'b0;
            fe_q    <= 1'b0;
            ovr_q   <= 1'b0;
        end else begin
            st_q    <= st_d;
            smp_q   <= smp_d;
            bit_q   <= bit_d;
            votes_q <= votes_d;
            sh_q    <= sh_d;
            prev_q  <= prev_d;
            push_q  <= push_d;
            fe_q    <= fe_d;
            ovr_q   <= ovr_d;
        end
    end

    // short frames land right-justified
    logic [DATA_BITS-1:0] aligned;
    assign aligned = sh_q >> (DATA_BITS - int'(data_bits));

    ucdr_fifo #(
        .WIDTH (DATA_BITS + 1),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .flush     (flush),
        .in_data   ({fe_q, aligned}), // [RULE16]
        .in_valid  (push_q),
        .in_ready  (fifo_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_valid),
        .out_ready (rx_ready)
    );

    assign rx_data          = fifo_out[DATA_BITS-1:0];
    assign frame_error_flag = fifo_out[DATA_BITS];
    assign rx_valid         = fifo_valid;
    assign rx_overrun       = ovr_q;

    a_idle_counter: assert property (@(posedge clock) disable iff (rst)
        st_q == UCDR_IDLE && $past(st_q) == UCDR_IDLE
        |-> smp_q == 5'd0) // [RULE2]
        else $error("sample count moved while idle");
    a_start_begin: assert property (@(posedge clock) disable iff (rst)
        st_q == UCDR_START && $past(st_q) == UCDR_IDLE |-> smp_q == 5'd2)
        else $error("start detect did not number first sample"); // [RULE3]
    a_noise_reject: assert property (@(posedge clock) disable iff (rst)
        st_q == UCDR_START && tick_q && smp_q == vfirst + 5'd2 && vote
        |=> st_q == UCDR_IDLE) // [RULE6]
        else $error("noise start not rejected");
    a_sample_range: assert property (@(posedge clock) disable iff (rst)
        st_q == UCDR_BITS |-> smp_q <= spb) // [RULE8]
        else $error("sample state past bit length");
    a_stop_push: assert property (@(posedge clock) disable iff (rst)
        st_q == UCDR_STOP && tick_q && smp_q == vfirst + 5'd2
        && receiver_enable_bit |=> push_q && fe_q == !$past(vote))
        else $error("stop bit result wrong"); // [RULE11]
    a_disable_abort: assert property (@(posedge clock) disable iff (rst)
        !receiver_enable_bit |=> st_q == UCDR_IDLE && !rx_valid)
        else $error("disable did not abort"); // [RULE17]
    a_stop_idle: assert property (@(posedge clock) disable iff (rst)
        push_q |-> st_q == UCDR_IDLE) // [RULE12]
        else $error("not hunting after stop vote");
    a_spb_mode: assert property (@(posedge clock) disable iff (rst)
        spb == (double_speed_select ? 5'd8 : 5'd16)) // [RULE1]
        else $error("wrong samples per bit");
    a_start_sync: assert property (@(posedge clock) disable iff (rst)
        st_q == UCDR_START && tick_q && smp_q == vfirst + 5'd2 && !vote
        && receiver_enable_bit
        |=> st_q == UCDR_BITS && smp_q == vfirst + 5'd3) // [RULE7]
        else $error("start bit did not realign timing");
    a_bit_wrap: assert property (@(posedge clock) disable iff (rst)
        st_q == UCDR_BITS && tick_q && smp_q == spb && receiver_enable_bit
        |=> smp_q == 5'd1) // [RULE8]
        else $error("sample state did not wrap");
    a_votes_idle: assert property (@(posedge clock) disable iff (rst)
        st_q == UCDR_IDLE |-> votes_q == 2'd0) // [RULE6]
        else $error("vote count left over in idle");
    a_stop_entry: assert property (@(posedge clock) disable iff (rst)
        st_q == UCDR_STOP && $past(st_q) == UCDR_BITS
        |-> bit_q == data_bits) // [RULE10]
        else $error("stop entered at wrong bit count");
    a_push_once: assert property (@(posedge clock) disable iff (rst)
        push_q |=> !push_q) // [RULE10]
        else $error("frame pushed twice");
    a_tick_rate: assert property (@(posedge clock) disable iff (rst)
        receiver_enable_bit && div_q == 16'h0000 |=> tick_q) // [RULE1]
        else $error("sample tick missing");
    a_vote_pos: assert property (@(posedge clock) disable iff (rst)
        vfirst == (double_speed_select ? 5'd4 : 5'd8)) // [RULE4] [RULE5]
        else $error("wrong voting samples");
    a_overrun_set: assert property (@(posedge clock) disable iff (rst)
        push_q && !fifo_ready |=> rx_overrun) // [RULE16]
        else $error("dropped frame not flagged");
    // a held head word must not slip while the consumer stalls
    a_head_hold: assert property (@(posedge clock) disable iff (rst)
        rx_valid && !rx_ready && receiver_enable_bit
        |=> rx_valid && $stable(rx_data)) // [RULE16]
        else $error("head word changed while stalled");

endmodule : ucdr_rx

// [test/ucdr_tx_model.sv]
`timescale 1ns/10ps
module ucdr_tx_model (
    output logic line
);
    logic clock;
    assign clock = test_uart_rx_clock_data_recovery.clock;
    // idle line rests high between frames
    initial line = 1'b1;
    task automatic hold(input logic v, input int n);
        line = v;
        repeat (n) @(posedge clock);
        #1;
    endtask : hold
    // exact bit rate, so this end spends none of the error budget
    // glitch flips the centre sample of the first data bit only
    task automatic send(input logic [8:0] d, input int nbits,
                        input logic stop_v, input int spb,
                        input int stop_len, input bit glitch);
        @(posedge clock);
        #1;
        hold(1'b0, spb);
        for (int i = 0; i < nbits; i++) begin
            if (glitch && i == 0) begin
                hold(d[0], spb / 2);
                hold(~d[0], 1);
                hold(d[0], spb - spb / 2 - 1);
            end else begin
                hold(d[i], spb);
            end
        end
        hold(stop_v, stop_len);
        line = 1'b1;
    endtask : send
endmodule : ucdr_tx_model

// [test/test_uart_rx_clock_data_recovery.sv]
`timescale 1ns/10ps
module test_uart_rx_clock_data_recovery;
    logic       clock;
    logic       rst;
    logic       rxd;
    logic       en;
    logic       ds;
    logic [3:0] data_bits;
    logic       rx_ready;
    logic [8:0] rx_data;
    logic       fe;
    logic       rx_valid;
    logic       ovr;
    int         num_errors;
    int         samples_checked;

    ucdr_tx_model tx (.line(rxd));

    ucdr_rx #(.DATA_BITS(9), .DEPTH(8), .BAUD_DIV(16'h0000)) dut (
        .clock(clock), .rst(rst), .rxd(rxd),
        .receiver_enable_bit(en), .double_speed_select(ds),
        .data_bits(data_bits), .baud_divisor_value(16'h0000),
        .rx_data(rx_data), .frame_error_flag(fe), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_overrun(ovr));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic check(input string nm, input logic [9:0] seen,
                         input logic [9:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic final_report;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    // bounded wait for the head word, then pop it
    task automatic get(input logic [8:0] d, input logic f);
        int n;
        n = 0;
        while (rx_valid !== 1'b1 && n < 400) begin
            cyc(1);
            n++;
        end
        check("rx_valid", {9'h000, rx_valid}, 10'h001);
        check("rx_data", {1'b0, rx_data}, {1'b0, d});
        check("frame_error_flag", {9'h000, fe}, {9'h000, f});
        rx_ready = 1'b1;
        cyc(1);
        rx_ready = 1'b0;
    endtask : get

    task automatic t_basic;
        tx.send(9'h0a5, 8, 1'b1, 16, 32, 1'b0);
        get(9'h0a5, 1'b0);
    endtask : t_basic

    task automatic t_frame_err;
        tx.send(9'h03c, 8, 1'b0, 16, 16, 1'b0);
        get(9'h03c, 1'b1);
    endtask : t_frame_err

    task automatic t_noise;
        tx.hold(1'b0, 3);
        tx.hold(1'b1, 60);
        check("noise", {9'h000, rx_valid}, 10'h000);
        tx.send(9'h05a, 8, 1'b1, 16, 16, 1'b0);
        get(9'h05a, 1'b0);
    endtask : t_noise

    task automatic t_glitch;
        tx.send(9'h0c3, 8, 1'b1, 16, 16, 1'b1);
        get(9'h0c3, 1'b0);
    endtask : t_glitch

    task automatic t_double;
        ds = 1'b1;
        data_bits = 4'h5;
        tx.send(9'h015, 5, 1'b1, 8, 8, 1'b0);
        get(9'h015, 1'b0);
        ds = 1'b0;
        data_bits = 4'h8;
    endtask : t_double

    // stop bit cut short: next start follows the stop vote after two high samples
    task automatic t_b2b;
        tx.send(9'h011, 8, 1'b1, 16, 11, 1'b0);
        tx.send(9'h0e0, 8, 1'b1, 16, 16, 1'b0);
        get(9'h011, 1'b0);
        get(9'h0e0, 1'b0);
    endtask : t_b2b

    task automatic t_fill;
        for (int i = 0; i < 9; i++) begin
            tx.send(9'(i * 17), 8, 1'b1, 16, 16, 1'b0);
        end
        cyc(4);
        check("overrun set", {9'h000, ovr}, 10'h001);
        for (int i = 0; i < 8; i++) begin
            get(9'(i * 17), 1'b0);
        end
        cyc(3);
        check("drained", {9'h000, rx_valid}, 10'h000);
        tx.send(9'h0f0, 8, 1'b1, 16, 16, 1'b0);
        get(9'h0f0, 1'b0);
        check("overrun clear", {9'h000, ovr}, 10'h000);
    endtask : t_fill

    // disabling mid-frame loses the frame and flushes the buffer
    task automatic t_abort;
        tx.send(9'h055, 8, 1'b1, 16, 16, 1'b0);
        fork
            tx.send(9'h0aa, 8, 1'b1, 16, 16, 1'b0);
            begin
                cyc(70);
                en = 1'b0;
            end
        join
        cyc(5);
        en = 1'b1;
        cyc(20);
        check("abort", {9'h000, rx_valid}, 10'h000);
        t_basic();
    endtask : t_abort

    initial begin
        num_errors = 0;
        samples_checked = 0;
        rst = 1'b1;
        en = 1'b1;
        ds = 1'b0;
        data_bits = 4'h8;
        rx_ready = 1'b0;
        cyc(6);
        rst = 1'b0;
        cyc(4);
        t_basic();
        t_frame_err();
        t_noise();
        t_glitch();
        t_double();
        t_b2b();
        t_fill();
        t_abort();
        final_report();
    end

    initial begin
        repeat (30000) @(posedge clock);
        num_errors++;
        final_report();
    end
endmodule : test_uart_rx_clock_data_recovery
